// ### ohi_pkg.sv
package ohi_pkg;

    // Link modes recognised from the three static select inputs.
    typedef enum logic [2:0] {
        OHI_SPI4,
        OHI_SPI3,
        OHI_I2C,
        OHI_P6800,
        OHI_P8080,
        OHI_NONE
    } ohi_mode_e;

    // Select patterns, packed as {bit2, bit1, bit0}.
    localparam logic [2:0] SEL_SPI3 = 3'h1;
    localparam logic [2:0] SEL_SPI4 = 3'h0;
    localparam logic [2:0] SEL_P6800 = 3'h4;
    localparam logic [2:0] SEL_P8080 = 3'h6;
    localparam logic [2:0] SEL_I2C = 3'h2;

    // Upper six bits of the I2C slave address; the value is arbitrary.
    localparam logic [5:0] I2C_ADDR_BASE = 6'h15;

    // Panel geometry: 128 columns, 64 rows in 8 pages, 1/64 duty.
    localparam int PANEL_COLS = 128;
    localparam int PANEL_ROWS = 64;
    localparam logic [6:0] COL_LAST = 7'h7F;
    localparam logic [5:0] ROW_LAST = 6'h3F;

    // Cycles after reset release during which the select pins are sampled.
    localparam logic [1:0] CAPTURE_CYCLES = 2'h3;

    // Row scan period, rounded up to whole clock cycles.
    localparam int CLK_PERIOD_PS = 5000;
    localparam int ROW_TIME_NS = 1000;
    localparam int ROW_CYCLES = (ROW_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam logic [7:0] ROW_COUNT_LAST = 8'(ROW_CYCLES - 1);

endpackage : ohi_pkg

// ### ohi_host_port.sv
`timescale 1ns/1ps
// What this block does
// RQ1: Select pins choose serial, parallel or I2C link.
// RQ2: Ignore the bus unless chip select low.
// RQ3: Initialise while reset low; host keeps high.
// RQ4: Control high means data, low means command.
// RQ5: I2C uses control pin as address bit.
// RQ6: Host grounds control pin in 3-wire mode.
// RQ7: 6800 mode: read/write pin picks the direction.
// RQ8: 8080 mode: write strobe low starts write.
// RQ9: 6800 mode: enable high starts the cycle.
// RQ10: 8080 mode: enable pin is read strobe.
// RQ11: Host grounds strobe pins in serial modes.
// RQ12: Eight data pins form a two-way bus.
// RQ13: Serial: line 0 clock, line 1 data.
// RQ14: I2C: lines 1,2 data in/out, 0 clock.
// RQ15: Drive 128 by 64 panel at 1/64 duty.
// RQ16: Select pattern sampled at reset, then static.
module ohi_host_port (
    input wire logic clk,
    input wire logic rst,
    input wire logic link_clk,
    input wire logic link_select_bit0,
    input wire logic link_select_bit1,
    input wire logic link_select_bit2,
    input wire logic chip_select_n,
    input wire logic init_reset_n,
    input wire logic data_cmd_sel,
    input wire logic read_write_sel,
    input wire logic enable_read_n,
    input wire logic [7:0] host_data_bus_in,
    output logic [7:0] host_data_bus_out,
    output logic [7:0] host_data_bus_oe,
    input wire logic [7:0] read_data,
    output logic read_req,
    output logic cmd_valid,
    output logic data_valid,
    output logic [7:0] byte_out,
    output logic [6:0] write_col,
    output logic [2:0] write_page,
    output logic [5:0] row_scan,
    output logic init_active,
    output ohi_pkg::ohi_mode_e link_mode
);

    // Two-stage synchronisers for every pin; stage 1 feeds only stage 2.
    localparam int NPIN = 17;
    logic [NPIN-1:0] pin_raw;
    logic [NPIN-1:0] pin_m;
    logic [NPIN-1:0] pin_s;
    logic [NPIN-1:0] pin_q;
    assign pin_raw = {init_reset_n, chip_select_n, data_cmd_sel, read_write_sel, enable_read_n,
                      link_select_bit2, link_select_bit1, link_select_bit0, host_data_bus_in,
                      1'b0};
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pin_m <= '0;
            pin_s <= '0;
            pin_q <= '0;
        end else begin
            pin_m <= pin_raw;
            pin_s <= pin_m;
            pin_q <= pin_s;
        end
    end

    logic init_n_s;
    logic cs_low;
    logic dc_s;
    logic rw_s;
    logic erd_s;
    logic erd_q;
    logic wr_s;
    logic wr_q;
    logic [2:0] sel_s;
    logic [7:0] dat_s;
    logic scl_s;
    logic scl_q;
    logic sda_s;
    logic sda_q;
    assign init_n_s = pin_s[16];
    assign cs_low = ~pin_s[15];
    assign dc_s = pin_s[14];
    assign rw_s = pin_s[13];
    assign wr_s = pin_s[13];
    assign wr_q = pin_q[13];
    assign erd_s = pin_s[12];
    assign erd_q = pin_q[12];
    assign sel_s = pin_s[11:9];
    assign dat_s = pin_s[8:1];
    assign scl_s = pin_s[1];
    assign scl_q = pin_q[1];
    assign sda_s = pin_s[2];
    assign sda_q = pin_q[2];

    // Initialisation runs while the reset pin is low, and the bus is dead meanwhile.
    logic busy;
    assign busy = ~init_n_s; // RQ3
    assign init_active = busy;

    // The pattern is taken only in the first cycles after release or during
    // initialisation, so a stray change mid-operation cannot retarget the link.
    logic [1:0] cap_cnt;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cap_cnt <= '0;
            link_mode <= ohi_pkg::OHI_NONE;
        end else if (busy || cap_cnt != ohi_pkg::CAPTURE_CYCLES) begin // RQ16
            if (cap_cnt != ohi_pkg::CAPTURE_CYCLES) begin
                cap_cnt <= cap_cnt + 2'h1;
            end
            if (sel_s == ohi_pkg::SEL_SPI3) begin // RQ1
                link_mode <= ohi_pkg::OHI_SPI3;
            end else if (sel_s == ohi_pkg::SEL_SPI4) begin
                link_mode <= ohi_pkg::OHI_SPI4;
            end else if (sel_s == ohi_pkg::SEL_P6800) begin
                link_mode <= ohi_pkg::OHI_P6800;
            end else if (sel_s == ohi_pkg::SEL_P8080) begin
                link_mode <= ohi_pkg::OHI_P8080;
            end else if (sel_s == ohi_pkg::SEL_I2C) begin
                link_mode <= ohi_pkg::OHI_I2C;
            end else begin
                link_mode <= ohi_pkg::OHI_NONE;
            end
        end
    end

    // Link domain: each serial clock rise captures one bit and the control level,
    // then flips a toggle. The held values stay put for a whole link period,
    // far longer than the three clk cycles the toggle needs to cross.
    logic l_bit;
    logic l_dc;
    logic l_tog;
    always_ff @(posedge link_clk or posedge rst) begin
        if (rst) begin
            l_bit <= 1'b0;
            l_dc <= 1'b0;
            l_tog <= 1'b0;
        end else if (!chip_select_n) begin // RQ2
            l_bit <= host_data_bus_in[1]; // RQ13
            l_dc <= data_cmd_sel;
            l_tog <= ~l_tog;
        end
    end

    logic tog_m;
    logic tog_s;
    logic tog_q;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tog_m <= 1'b0;
            tog_s <= 1'b0;
            tog_q <= 1'b0;
        end else begin
            tog_m <= l_tog;
            tog_s <= tog_m;
            tog_q <= tog_s;
        end
    end

    // Serial byte assembly: 4-wire takes 8 bits and the control pin, 3-wire
    // takes a leading control bit and then 8 data bits.
    logic [3:0] s_cnt;
    logic [7:0] s_shift;
    logic s_fire;
    logic s_dc;
    logic [7:0] s_byte;
    logic s_bit_ev;
    logic s_spi3;
    assign s_spi3 = (link_mode == ohi_pkg::OHI_SPI3);
    assign s_bit_ev = (tog_s != tog_q) && cs_low && !busy &&
                      (s_spi3 || link_mode == ohi_pkg::OHI_SPI4);
    assign s_fire = s_bit_ev && (s_cnt == (s_spi3 ? 4'h8 : 4'h7));
    assign s_byte = {s_shift[6:0], l_bit};
    assign s_dc = s_spi3 ? s_shift[7] : l_dc; // RQ4
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_cnt <= '0;
            s_shift <= '0;
        end else if (!cs_low || busy) begin
            s_cnt <= '0;
        end else if (s_bit_ev) begin
            s_shift <= s_byte;
            s_cnt <= s_fire ? 4'h0 : s_cnt + 4'h1;
        end
    end

    // Parallel strobes: 6800 enable rise starts a cycle and the write byte is
    // taken at the fall; 8080 write low starts and data is taken at the rise.
    logic p68;
    logic p80;
    logic p_wr_open;
    logic p_fire;
    logic p_rd_start;
    logic p_rd_hold;
    assign p68 = (link_mode == ohi_pkg::OHI_P6800);
    assign p80 = (link_mode == ohi_pkg::OHI_P8080);
    assign p_fire = !busy && p_wr_open && ((p68 && !erd_s && erd_q) || (p80 && wr_s && !wr_q));
    assign p_rd_start = cs_low && !busy &&
                        ((p68 && erd_s && !erd_q && rw_s) || (p80 && !erd_s && erd_q));
    assign p_rd_hold = cs_low && !busy && ((p68 && erd_s && rw_s) || (p80 && !erd_s));
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            p_wr_open <= 1'b0;
        end else if (busy || !cs_low || p_fire) begin
            p_wr_open <= 1'b0;
        end else if (p68 && erd_s && !erd_q && !rw_s) begin // RQ9 RQ7
            p_wr_open <= 1'b1;
        end else if (p80 && !wr_s && wr_q) begin // RQ8
            p_wr_open <= 1'b1;
        end
    end

    // I2C slave, oversampled on clk: line 0 is the clock, line 1 the data in.
    typedef enum {I_ADDR, I_CTRL, I_DATA, I_SKIP} ohi_i2c_e;
    ohi_i2c_e i_phase;
    logic [3:0] i_cnt;
    logic [7:0] i_shift;
    logic i_ack;
    logic i_co;
    logic i_dc;
    logic i_on;
    logic i_rise;
    logic i_fall;
    logic i_fire;
    logic i_match;
    assign i_on = (link_mode == ohi_pkg::OHI_I2C) && cs_low && !busy;
    assign i_rise = scl_s && !scl_q;
    assign i_fall = !scl_s && scl_q;
    assign i_match = (i_shift[7:1] == {ohi_pkg::I2C_ADDR_BASE, dc_s}) && !i_shift[0]; // RQ5
    assign i_fire = i_on && i_fall && i_cnt == 4'h8 && i_phase == I_DATA;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            i_phase <= I_SKIP;
            i_cnt <= '0;
            i_shift <= '0;
            i_ack <= 1'b0;
            i_co <= 1'b0;
            i_dc <= 1'b0;
        end else if (!i_on) begin
            i_phase <= I_SKIP;
            i_ack <= 1'b0;
        end else if (scl_s && sda_q && !sda_s) begin
            i_phase <= I_ADDR;
            i_cnt <= '0;
            i_ack <= 1'b0;
        end else if (scl_s && !sda_q && sda_s) begin
            i_phase <= I_SKIP;
            i_ack <= 1'b0;
        end else if (i_rise && i_cnt != 4'h9) begin
            if (i_cnt < 4'h8) begin
                i_shift <= {i_shift[6:0], sda_s}; // RQ14
            end
            i_cnt <= i_cnt + 4'h1;
        end else if (i_fall && i_cnt == 4'h9) begin
            i_ack <= 1'b0;
            i_cnt <= '0;
        end else if (i_fall && i_cnt == 4'h8) begin
            i_cnt <= 4'h9;
            case (i_phase)
                I_ADDR: begin
                    i_ack <= i_match;
                    i_phase <= i_match ? I_CTRL : I_SKIP;
                end
                I_CTRL: begin
                    i_ack <= 1'b1;
                    i_co <= i_shift[7];
                    i_dc <= i_shift[6];
                    i_phase <= I_DATA;
                end
                I_DATA: begin
                    i_ack <= 1'b1;
                    i_phase <= i_co ? I_CTRL : I_DATA;
                end
                default: begin
                    i_ack <= 1'b0;
                end
            endcase
        end
    end

    // One byte source per mode; the modes never overlap.
    logic next_fire;
    logic next_dc;
    logic [7:0] next_byte;
    always_comb begin
        next_fire = 1'b0;
        next_dc = 1'b0;
        next_byte = 8'h00;
        if (s_fire) begin
            next_fire = 1'b1;
            next_dc = s_dc;
            next_byte = s_byte;
        end else if (p_fire) begin
            next_fire = 1'b1;
            next_dc = dc_s;
            next_byte = dat_s;
        end else if (i_fire) begin
            next_fire = 1'b1;
            next_dc = i_dc;
            next_byte = i_shift;
        end
    end

    // Steer the byte to the command or data stream by the control level.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cmd_valid <= 1'b0;
            data_valid <= 1'b0;
            byte_out <= '0;
        end else begin
            cmd_valid <= next_fire && !next_dc; // RQ4
            data_valid <= next_fire && next_dc;
            if (next_fire) begin
                byte_out <= next_byte;
            end
        end
    end

    // Data bytes walk across 128 columns and then the next of 8 pages.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            write_col <= '0;
            write_page <= '0;
        end else if (busy) begin
            write_col <= '0;
            write_page <= '0;
        end else if (data_valid) begin // RQ15
            write_col <= write_col + 7'h01;
            if (write_col == ohi_pkg::COL_LAST) begin
                write_page <= write_page + 3'h1;
            end
        end
    end

    // Row scan: each of the 64 rows is driven for one row period in turn.
    logic [7:0] row_cnt;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            row_cnt <= '0;
            row_scan <= '0;
        end else if (busy) begin
            row_cnt <= '0;
            row_scan <= '0;
        end else if (row_cnt == ohi_pkg::ROW_COUNT_LAST) begin // RQ15
            row_cnt <= '0;
            row_scan <= row_scan + 6'h01;
        end else begin
            row_cnt <= row_cnt + 8'h01;
        end
    end

    // Read path: the answer is sampled the cycle read_req is high and driven
    // for as long as the read strobe stays asserted.
    logic rd_drive;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            read_req <= 1'b0;
            rd_drive <= 1'b0;
            host_data_bus_out <= '0;
        end else begin
            read_req <= p_rd_start; // RQ10 RQ7
            rd_drive <= p_rd_hold && (rd_drive || p_rd_start);
            if (read_req) begin
                host_data_bus_out <= read_data; // RQ12
            end else if (!rd_drive) begin
                host_data_bus_out <= '0;
            end
        end
    end

    // Line 2 pulls the I2C data line low for an acknowledge; open drain only.
    assign host_data_bus_oe = rd_drive ? 8'hFF : {5'h00, i_ack, 2'h0}; // RQ12 RQ14

    // Assertions.
    sequence strobe_rise_s;
        p68 && erd_s && !erd_q && !rw_s && cs_low && !busy;
    endsequence
    sequence strobe_fall_s;
        p68 && !erd_s && erd_q && cs_low;
    endsequence

    mode_static_a: assert property (@(posedge clk) disable iff (rst) // RQ16
        (!busy && cap_cnt == ohi_pkg::CAPTURE_CYCLES) |=> $stable(link_mode))
        else $error("link mode changed while operating");
    cs_gate_a: assert property (@(posedge clk) disable iff (rst) // RQ2
        (!cs_low && $past(!cs_low)) |=> !(cmd_valid || data_valid || read_req))
        else $error("bus activity accepted with chip select high");
    init_quiet_a: assert property (@(posedge clk) disable iff (rst) // RQ3
        busy |=> !(cmd_valid || data_valid) && write_col == 7'h00)
        else $error("activity during initialisation");
    dc_steer_a: assert property (@(posedge clk) disable iff (rst) // RQ4
        next_fire |=> (cmd_valid == !$past(next_dc)) && (data_valid == $past(next_dc)))
        else $error("byte sent to wrong stream");
    wr6800_a: assert property (@(posedge clk) disable iff (rst) // RQ9
        strobe_rise_s ##1 (cs_low && erd_s)[*5] ##1 strobe_fall_s |=> (cmd_valid || data_valid))
        else $error("6800 write lost");
    rd8080_a: assert property (@(posedge clk) disable iff (rst) // RQ10
        (p80 && cs_low && !busy && !erd_s && erd_q) |=> read_req ##1 (host_data_bus_oe == 8'hFF))
        else $error("8080 read not answered");
    i2c_ack_a: assert property (@(posedge clk) disable iff (rst) // RQ5
        (i_on && i_fall && i_cnt == 4'h8 && i_phase == I_ADDR && !i_match) |=> !i_ack)
        else $error("acknowledged foreign address");
    row_wrap_a: assert property (@(posedge clk) disable iff (rst) // RQ15
        (!busy && row_scan == ohi_pkg::ROW_LAST && row_cnt == ohi_pkg::ROW_COUNT_LAST)
        |=> row_scan == 6'h00)
        else $error("row scan does not wrap at 64");
    spi_fire_a: assert property (@(posedge clk) disable iff (rst) // RQ13
        s_fire |=> (byte_out == $past(s_byte)))
        else $error("serial byte corrupted");

endmodule : ohi_host_port

// ### ohi_host_model.sv
`timescale 1ns/1ps
// Host controller model. It owns the data pins and works out the level the
// display sees from its own drive and the display's per-pin enables.
module ohi_host_model (
    input wire logic clk,
    input wire logic [7:0] dut_out,
    input wire logic [7:0] dut_oe,
    output logic link_clk,
    output logic [2:0] sel,
    output logic cs_n,
    output logic init_n,
    output logic dc,
    output logic rw,
    output logic en,
    output logic [7:0] bus
);
    logic [1:0] kind;
    logic is8080;
    logic drv_en;
    logic serial_data_input;
    logic sda_low;
    logic scl;
    logic [7:0] drv_val;
    logic [7:0] last_val;

    // Released parallel pins show the inverse of the last value, so a
    // design that samples a floating bus cannot pass by luck.
    always_comb begin
        bus = 8'h00;
        if (kind == 2'h2) begin
            bus[0] = scl;
            bus[1] = ~(sda_low | dut_oe[2]);
            bus[2] = ~(sda_low | dut_oe[2]);
        end else if (kind == 2'h1) begin
            bus[0] = link_clk;
            bus[1] = serial_data_input;
        end else begin
            for (int i = 0; i < 8; i++) begin
                bus[i] = dut_oe[i] ? dut_out[i] : (drv_en ? drv_val[i] : ~last_val[i]);
            end
        end
    end

    // Remember what was last put on the bus.
    always @(posedge clk) begin
        if (drv_en) begin
            last_val <= drv_val;
        end
    end

    // Every pin has a value from time zero.
    initial begin
        {link_clk, cs_n, init_n, dc, rw, en} = 6'h1C;
        sel = ohi_pkg::SEL_SPI4;
        {kind, is8080, drv_en, serial_data_input, sda_low, scl} = 7'h21;
        drv_val = 8'h00;
        last_val = 8'h00;
    end

    task automatic wait_n(input int n);
        repeat (n) @(negedge clk);
    endtask : wait_n

    // Strobes idle inactive; serial modes ground both strobe pins.
    task automatic set_mode(input logic [2:0] s, input logic d_c);
        sel = s;
        dc = d_c;
        kind = (s == ohi_pkg::SEL_I2C) ? 2'h2 : ((s == ohi_pkg::SEL_P6800) ? 2'h0 : 2'h1);
        if (s == ohi_pkg::SEL_P8080) begin
            kind = 2'h0;
        end
        is8080 = (s == ohi_pkg::SEL_P8080);
        rw = is8080;
        en = is8080;
        init_n = 1'b0;
        wait_n(8);
        init_n = 1'b1;
        wait_n(8);
    endtask : set_mode

    // Data is held a few cycles past the closing strobe edge for the synchroniser.
    task automatic par_write(input logic cs, input logic d_c, input logic [7:0] b);
        drv_val = b;
        drv_en = 1'b1;
        dc = d_c;
        cs_n = ~cs;
        wait_n(2);
        rw = 1'b0;
        en = 1'b1; // Raises the 6800 enable; keeps the 8080 read strobe idle.
        wait_n(6);
        rw = is8080;
        en = is8080;
        wait_n(4);
        cs_n = 1'b1;
        drv_en = 1'b0;
        wait_n(2);
    endtask : par_write

    task automatic par_read(output logic [7:0] got, output logic [7:0] got_oe);
        drv_en = 1'b0;
        cs_n = 1'b0;
        wait_n(2);
        rw = ~is8080 | rw;
        en = ~is8080;
        wait_n(8);
        got = dut_out;
        got_oe = dut_oe;
        rw = is8080;
        en = is8080;
        wait_n(6);
        cs_n = 1'b1;
        wait_n(2);
    endtask : par_read

    // The serial clock runs only inside a frame, off the system clock phase.
    task automatic spi_byte(input logic three, input logic d_c, input logic [7:0] b);
        logic [8:0] sh;
        int n;
        sh = {d_c, b};
        n = three ? 9 : 8;
        dc = three ? 1'b0 : d_c;
        cs_n = 1'b0;
        #3.7;
        for (int i = n - 1; i >= 0; i--) begin
            serial_data_input = sh[i];
            #80 link_clk = 1'b1;
            #80 link_clk = 1'b0;
        end
        wait_n(8);
        cs_n = 1'b1;
        wait_n(2);
    endtask : spi_byte

    task automatic i2c_byte(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            sda_low = ~b[i];
            wait_n(2);
            scl = 1'b1;
            wait_n(6);
            scl = 1'b0;
            wait_n(4);
        end
        sda_low = 1'b0;
        wait_n(2);
        scl = 1'b1;
        wait_n(3);
        ack = dut_oe[2];
        wait_n(3);
        scl = 1'b0;
        wait_n(4);
    endtask : i2c_byte

    // Start, address, control and one byte, then stop; a refused address ends early.
    task automatic i2c_write(input logic [7:0] a, input logic [7:0] c, input logic [7:0] b,
                             output logic ack);
        logic more;
        cs_n = 1'b0;
        sda_low = 1'b1;
        wait_n(6);
        scl = 1'b0;
        wait_n(4);
        i2c_byte(a, ack);
        if (ack) begin
            i2c_byte(c, more);
            i2c_byte(b, more);
        end
        sda_low = 1'b1;
        wait_n(2);
        scl = 1'b1;
        wait_n(6);
        sda_low = 1'b0;
        wait_n(6);
        cs_n = 1'b1;
    endtask : i2c_write
endmodule : ohi_host_model

// ### test_ohi_host_port.sv
`timescale 1ns/1ps
// Checks the host port in every link mode through the host model.
module test_ohi_host_port;
    logic clk;
    logic rst;
    logic link_clk;
    logic [2:0] sel;
    logic cs_n, init_n, dc, rw, en, read_req, cmd_valid, data_valid, init_active, ack;
    logic [7:0] bus, dout, doe, read_data, byte_out, got, got_oe;
    logic [6:0] write_col;
    logic [2:0] write_page;
    logic [5:0] row_scan, r0;
    ohi_pkg::ohi_mode_e link_mode;
    logic [7:0] n_cmd = 8'h00, n_dat = 8'h00, n_rd = 8'h00, sc, sd, sr;
    int error_cnt = 0, compares = 0, k;
    logic [2:0] pats [5] = '{ohi_pkg::SEL_SPI4, ohi_pkg::SEL_SPI3, ohi_pkg::SEL_I2C,
                             ohi_pkg::SEL_P6800, ohi_pkg::SEL_P8080};
    ohi_pkg::ohi_mode_e modes [5] = '{ohi_pkg::OHI_SPI4, ohi_pkg::OHI_SPI3, ohi_pkg::OHI_I2C,
                                      ohi_pkg::OHI_P6800, ohi_pkg::OHI_P8080};

    ohi_host_model host_u (.clk(clk), .dut_out(dout), .dut_oe(doe), .link_clk(link_clk),
        .sel(sel), .cs_n(cs_n), .init_n(init_n), .dc(dc), .rw(rw), .en(en), .bus(bus));

    ohi_host_port dut_u (.clk(clk), .rst(rst), .link_clk(link_clk),
        .link_select_bit0(sel[0]), .link_select_bit1(sel[1]), .link_select_bit2(sel[2]),
        .chip_select_n(cs_n), .init_reset_n(init_n), .data_cmd_sel(dc), .read_write_sel(rw),
        .enable_read_n(en), .host_data_bus_in(bus), .host_data_bus_out(dout),
        .host_data_bus_oe(doe), .read_data(read_data), .read_req(read_req),
        .cmd_valid(cmd_valid), .data_valid(data_valid), .byte_out(byte_out),
        .write_col(write_col), .write_page(write_page), .row_scan(row_scan),
        .init_active(init_active), .link_mode(link_mode));

    // A 200 MHz system clock.
    initial clk = 1'b0;
    always #2.5 clk = ~clk;

    // Count the one-cycle pulses so that a lost or doubled pulse shows up.
    always @(posedge clk) begin
        n_cmd <= n_cmd + {7'h00, cmd_valid};
        n_dat <= n_dat + {7'h00, data_valid};
        n_rd <= n_rd + {7'h00, read_req};
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic snap();
        sc = n_cmd;
        sd = n_dat;
        sr = n_rd;
    endtask : snap

    task automatic expect_ev(input logic [7:0] d, input logic [7:0] c, input logic [7:0] r,
                             input logic [7:0] b);
        check(n_dat - sd, d);
        check(n_cmd - sc, c);
        check(n_rd - sr, r);
        check(byte_out, b);
    endtask : expect_ev

    task automatic complete_run();
        $display("compares %0d, mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : complete_run

    // The tests need about 14000 cycles; a hang is cut off well past that.
    initial begin
        #200000;
        error_cnt++;
        complete_run();
    end

    initial begin
        rst = 1'b1;
        read_data = 8'hA5;
        repeat (8) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        host_u.wait_n(8);
        for (int i = 0; i < 5; i++) begin
            fork
                host_u.set_mode(pats[i], 1'b0);
                begin
                    host_u.wait_n(5);
                    check(8'(init_active), 8'h01);
                end
            join
            check(8'(link_mode), 8'(modes[i]));
        end
        host_u.sel = ohi_pkg::SEL_SPI4;
        host_u.wait_n(12);
        check(8'(link_mode), 8'(ohi_pkg::OHI_P8080));
        host_u.sel = ohi_pkg::SEL_P8080;
        $display("test modes done");
        snap();
        host_u.par_write(1'b1, 1'b1, 8'h5A);
        expect_ev(8'h01, 8'h00, 8'h00, 8'h5A);
        check({1'b0, write_col}, 8'h01);
        check({5'h00, write_page}, 8'h00);
        host_u.par_read(got, got_oe);
        expect_ev(8'h01, 8'h00, 8'h01, 8'h5A);
        check(got, 8'hA5);
        check(got_oe, 8'hFF);
        check(doe, 8'h00);
        $display("test 8080 done");
        host_u.set_mode(ohi_pkg::SEL_P6800, 1'b0);
        snap();
        host_u.par_write(1'b1, 1'b0, 8'h3C);
        expect_ev(8'h00, 8'h01, 8'h00, 8'h3C);
        host_u.par_write(1'b1, 1'b1, 8'h81);
        expect_ev(8'h01, 8'h01, 8'h00, 8'h81);
        host_u.par_write(1'b0, 1'b1, 8'h55);
        expect_ev(8'h01, 8'h01, 8'h00, 8'h81);
        host_u.par_read(got, got_oe);
        expect_ev(8'h01, 8'h01, 8'h01, 8'h81);
        check(got, 8'hA5);
        check(got_oe, 8'hFF);
        $display("test 6800 done");
        host_u.set_mode(ohi_pkg::SEL_SPI4, 1'b0);
        snap();
        host_u.spi_byte(1'b0, 1'b1, 8'hC3);
        expect_ev(8'h01, 8'h00, 8'h00, 8'hC3);
        host_u.spi_byte(1'b0, 1'b0, 8'h2E);
        expect_ev(8'h01, 8'h01, 8'h00, 8'h2E);
        host_u.set_mode(ohi_pkg::SEL_SPI3, 1'b0);
        snap();
        host_u.spi_byte(1'b1, 1'b1, 8'h96);
        expect_ev(8'h01, 8'h00, 8'h00, 8'h96);
        host_u.spi_byte(1'b1, 1'b0, 8'h1F);
        expect_ev(8'h01, 8'h01, 8'h00, 8'h1F);
        $display("test serial done");
        host_u.set_mode(ohi_pkg::SEL_I2C, 1'b1);
        snap();
        host_u.i2c_write({ohi_pkg::I2C_ADDR_BASE, 2'h2}, 8'h40, 8'h6B, ack);
        check(8'(ack), 8'h01);
        expect_ev(8'h01, 8'h00, 8'h00, 8'h6B);
        host_u.i2c_write({ohi_pkg::I2C_ADDR_BASE, 2'h0}, 8'h00, 8'h11, ack);
        check(8'(ack), 8'h00);
        expect_ev(8'h01, 8'h00, 8'h00, 8'h6B);
        $display("test i2c done");
        for (int j = 0; j < 2; j++) begin
            r0 = row_scan;
            k = 0;
            while (row_scan === r0 && k < 400) begin
                @(negedge clk);
                k++;
            end
        end
        check(8'(k), 8'(ohi_pkg::ROW_CYCLES));
        check({2'h0, row_scan}, {2'h0, r0 + 6'h01});
        // Ride the scan up to the last row and one row period more to see the wrap.
        k = 0;
        while (row_scan !== ohi_pkg::ROW_LAST && k < 13000) begin
            @(negedge clk);
            k++;
        end
        repeat (ohi_pkg::ROW_CYCLES) @(negedge clk);
        check({2'h0, row_scan}, 8'h00);
        $display("test row scan done");
        complete_run();
    end
endmodule : test_ohi_host_port
